/* File: hdl/sysmt_pkg.sv */
// Purpose: types for the system configuration memory-type control block
// Assumes: one clock, synchronous active-low reset
// Notes:   offsets, positions and reset values live in sysmt_map.svh
package sysmt_pkg;
  // ------------------------------------------------------------
  // register access request from the privileged msr path
  // ------------------------------------------------------------
  typedef struct packed {
    logic        rdEn;
    logic        wrEn;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sysmt_req_type;

  // ------------------------------------------------------------
  // enable fields of the configuration word
  // ------------------------------------------------------------
  typedef struct packed {
    logic fixedAttrEnable;
    logic fixedAttrModifyEnable;
    logic variableRangeEnable;
    logic highLimitEnable;
    logic forceWritebackHigh;
  } sysmt_cfg_type;

  // ------------------------------------------------------------
  // answer to a request
  // ------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [31:0] rdata;
  } sysmt_rsp_type;

  // ------------------------------------------------------------
  // memory-type decision inputs and outputs, and the msr answer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SYSMT_UC = 3'h0,
    SYSMT_WC = 3'h1,
    SYSMT_WT = 3'h4,
    SYSMT_WP = 3'h5,
    SYSMT_WB = 3'h6
  } sysmt_memtype_type;

  typedef enum {
    SYSMT_IDLE,
    SYSMT_ANSWER
  } sysmt_state_type;
endpackage : sysmt_pkg

/* File: hdl/sysmt_map.svh */
// Purpose: offsets, field positions and reset values of the block
// Assumes: 32-bit register word
// Notes:   included by bare name
`ifndef SYSMT_MAP_SVH
`define SYSMT_MAP_SVH
`define SYSMT_CFG_ADDR      32'hc0010010
`define SYSMT_FIXED_EN_BIT  18
`define SYSMT_FIXED_MOD_BIT 19
`define SYSMT_VAR_EN_BIT    20
`define SYSMT_HIGH_EN_BIT   21
`define SYSMT_FORCE_WB_BIT  22
`define SYSMT_CFG_RESET     5'h00
`define SYSMT_FOUR_GB       40'h0100000000
`define SYSMT_ATTR_RESET    2'h0
`endif

/* File: hdl/sysmt_attr_mem.sv */
// Purpose: storage for the read/write-memory attribute pairs of fixed ranges
// Assumes: one write and one read port, registered read data
// Notes:   depth is the number of fixed-range type fields
`include "sysmt_map.svh"
module sysmt_attr_mem #(
  parameter int DEPTH = 88,
  parameter int AW    = 7
) (
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [1:0]    wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [1:0]    rdData
);
  import sysmt_pkg::*;

  logic [1:0] mem_ff [DEPTH];
  logic [1:0] rdData_ff;
  logic [1:0] nxt_rdData;

  always_comb begin
    nxt_rdData = (int'(rdAddr) < DEPTH) ? mem_ff[rdAddr] : 2'h0;
  end

  // ------------------------------------------------------------
  // storage cells
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : gCell
      logic [1:0] nxt_cell;
      always_comb begin
        nxt_cell = mem_ff[gi];
        if (wrEn && int'(wrAddr) == gi) begin
          nxt_cell = wrData;
        end
      end
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          mem_ff[gi] <= `SYSMT_ATTR_RESET;
        end else begin
          mem_ff[gi] <= nxt_cell;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdData_ff <= 2'h0;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign rdData = rdData_ff;
endmodule : sysmt_attr_mem

/* File: hdl/sysmt_ctrl.sv */
// Purpose: system configuration register and the memory typing it steers
// Assumes: requests come from the privileged msr path on mclk, one at a time
// Notes:   answer arrives two edges after a request; attribute reads go through memory
`include "sysmt_map.svh"
module sysmt_ctrl #(
  parameter int ATTR_DEPTH = 88,
  parameter int ATTR_AW    = 7,
  parameter int PA_W       = 40
) (
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  // msr access path
  input  wire sysmt_pkg::sysmt_req_type       cfgReq,
  output sysmt_pkg::sysmt_rsp_type            cfgRsp,
  // fixed-range attribute access path
  input  wire logic                           attrWrEn,
  input  wire logic                           attrRdEn,
  input  wire logic [ATTR_AW-1:0]             attrIdx,
  input  wire logic [1:0]                     attrWrData,
  output logic      [1:0]                     attrRdData,
  output logic                                attrRdValid,
  // memory-typing lookup
  input  wire logic [PA_W-1:0]                physAddr,
  input  wire logic [1:0]                     fixedAttrRaw,
  input  wire logic                           defaultTypeEnable,
  input  wire sysmt_pkg::sysmt_memtype_type   defaultMemType,
  input  wire logic                           rangeHit,
  input  wire sysmt_pkg::sysmt_memtype_type   rangeMemType,
  input  wire logic [PA_W-1:0]                highMemoryCeiling,
  output sysmt_pkg::sysmt_cfg_type            cfgOut,
  output logic [1:0]                          fixedAttrEffective,
  output logic                                lowLimitActive,
  output logic                                ioRangeActive,
  output logic                                highLimitActive,
  output sysmt_pkg::sysmt_memtype_type        memTypeOut
);
  import sysmt_pkg::*;

  // ------------------------------------------------------------
  // field decode, shared by read and write paths
  // ------------------------------------------------------------
  function automatic logic [31:0] packCfg(input sysmt_cfg_type c);
    logic [31:0] w;
    w = 32'h0;
    w[`SYSMT_FIXED_EN_BIT]  = c.fixedAttrEnable;
    w[`SYSMT_FIXED_MOD_BIT] = c.fixedAttrModifyEnable;
    w[`SYSMT_VAR_EN_BIT]    = c.variableRangeEnable;
    w[`SYSMT_HIGH_EN_BIT]   = c.highLimitEnable;
    w[`SYSMT_FORCE_WB_BIT]  = c.forceWritebackHigh;
    return w;
  endfunction : packCfg

  function automatic sysmt_cfg_type unpackCfg(input logic [31:0] w);
    sysmt_cfg_type c;
    c.fixedAttrEnable       = w[`SYSMT_FIXED_EN_BIT];
    c.fixedAttrModifyEnable = w[`SYSMT_FIXED_MOD_BIT];
    c.variableRangeEnable   = w[`SYSMT_VAR_EN_BIT];
    c.highLimitEnable       = w[`SYSMT_HIGH_EN_BIT];
    c.forceWritebackHigh    = w[`SYSMT_FORCE_WB_BIT];
    return c;
  endfunction : unpackCfg

  // ------------------------------------------------------------
  // configuration register and msr answer
  // ------------------------------------------------------------
  sysmt_cfg_type   cfg_ff;
  sysmt_cfg_type   nxt_cfg;
  sysmt_rsp_type   rsp_ff;
  sysmt_rsp_type   nxt_rsp;
  sysmt_state_type state_ff;
  sysmt_state_type nxt_state;
  logic            reqHit;

  always_comb begin
    reqHit    = (cfgReq.addr == `SYSMT_CFG_ADDR);
    nxt_cfg   = cfg_ff;
    nxt_rsp   = '0;
    nxt_state = state_ff;
    case (state_ff)
      SYSMT_IDLE: begin
        if (cfgReq.wrEn || cfgReq.rdEn) begin
          nxt_state = SYSMT_ANSWER;
          if (cfgReq.wrEn && reqHit) begin
            nxt_cfg = unpackCfg(cfgReq.wdata);
          end
        end
      end
      SYSMT_ANSWER: begin
        nxt_state   = SYSMT_IDLE;
        nxt_rsp.valid = 1'b1;
        nxt_rsp.hit   = reqHit;
        nxt_rsp.rdata = (reqHit && cfgReq.rdEn) ? packCfg(cfg_ff) : 32'h0;
      end
      default: begin
        nxt_state = SYSMT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cfg_ff   <= sysmt_cfg_type'(`SYSMT_CFG_RESET);
      rsp_ff   <= '0;
      state_ff <= SYSMT_IDLE;
    end else begin
      cfg_ff   <= nxt_cfg;
      rsp_ff   <= nxt_rsp;
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // fixed-range attribute bits; modify enable guards both ways
  // ------------------------------------------------------------
  logic [1:0] memRdData;
  logic       attrWrGo;
  logic       rdPend_ff;
  logic       nxt_rdPend;
  logic       rdMask_ff;
  logic       nxt_rdMask;
  logic       rdValid_ff;
  logic       nxt_rdValid;
  logic [1:0] attrRd_ff;
  logic [1:0] nxt_attrRd;

  always_comb begin
    attrWrGo    = attrWrEn && cfg_ff.fixedAttrModifyEnable;
    nxt_rdPend  = attrRdEn;
    nxt_rdMask  = cfg_ff.fixedAttrModifyEnable;
    nxt_rdValid = rdPend_ff;
    nxt_attrRd  = rdPend_ff ? (rdMask_ff ? memRdData : 2'h0) : attrRd_ff;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdPend_ff  <= 1'b0;
      rdMask_ff  <= 1'b0;
      rdValid_ff <= 1'b0;
      attrRd_ff  <= 2'h0;
    end else begin
      rdPend_ff  <= nxt_rdPend;
      rdMask_ff  <= nxt_rdMask;
      rdValid_ff <= nxt_rdValid;
      attrRd_ff  <= nxt_attrRd;
    end
  end

  sysmt_attr_mem #(
    .DEPTH (ATTR_DEPTH),
    .AW    (ATTR_AW)
  ) uAttrMem (
    .mclk    (mclk),
    .reset_n (reset_n),
    .wrEn    (attrWrGo),
    .wrAddr  (attrIdx),
    .wrData  (attrWrData),
    .rdAddr  (attrIdx),
    .rdData  (memRdData)
  );

  // ------------------------------------------------------------
  // memory typing, registered one cycle after the lookup inputs
  // ------------------------------------------------------------
  sysmt_memtype_type nxt_memType;
  sysmt_memtype_type memType_ff;
  logic [1:0]        nxt_fixedEff;
  logic [1:0]        fixedEff_ff;
  logic [2:0]        nxt_act;
  logic [2:0]        act_ff;
  logic              inHighWindow;

  always_comb begin
    nxt_fixedEff = cfg_ff.fixedAttrEnable ? fixedAttrRaw : 2'h0;
    nxt_act[0]   = cfg_ff.variableRangeEnable;
    nxt_act[1]   = cfg_ff.variableRangeEnable;
    nxt_act[2]   = cfg_ff.highLimitEnable;
    // window needs the ceiling itself enabled, otherwise it has no top
    inHighWindow = cfg_ff.highLimitEnable &&
                   (physAddr >= PA_W'(`SYSMT_FOUR_GB)) &&
                   (physAddr < highMemoryCeiling);
    nxt_memType  = SYSMT_UC;
    if (defaultTypeEnable) begin
      nxt_memType = defaultMemType;
      if (cfg_ff.forceWritebackHigh && inHighWindow) begin
        nxt_memType = SYSMT_WB;
      end
      if (rangeHit) begin
        nxt_memType = rangeMemType;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      memType_ff  <= SYSMT_UC;
      fixedEff_ff <= 2'h0;
      act_ff      <= 3'h0;
    end else begin
      memType_ff  <= nxt_memType;
      fixedEff_ff <= nxt_fixedEff;
      act_ff      <= nxt_act;
    end
  end

  assign cfgRsp             = rsp_ff;
  assign cfgOut             = cfg_ff;
  assign attrRdData         = attrRd_ff;
  assign attrRdValid        = rdValid_ff;
  assign fixedAttrEffective = fixedEff_ff;
  assign lowLimitActive     = act_ff[0];
  assign ioRangeActive      = act_ff[1];
  assign highLimitActive    = act_ff[2];
  assign memTypeOut         = memType_ff;
endmodule : sysmt_ctrl

/* File: sim/sysmt_ctrl_sva.sv */
// Purpose: port-level assertions for sysmt_ctrl
// Assumes: one mclk domain, reset_n synchronous active low
// Notes:   bound from the bench top file
module sysmt_ctrl_sva #(
  parameter int ATTR_AW = 7,
  parameter int PA_W    = 40
) (
  input wire logic                         mclk,
  input wire logic                         reset_n,
  input wire sysmt_pkg::sysmt_req_type     cfgReq,
  input wire sysmt_pkg::sysmt_rsp_type     cfgRsp,
  input wire logic                         attrWrEn,
  input wire logic                         attrRdEn,
  input wire logic [ATTR_AW-1:0]           attrIdx,
  input wire logic [1:0]                   attrWrData,
  input wire logic [1:0]                   attrRdData,
  input wire logic                         attrRdValid,
  input wire logic [PA_W-1:0]              physAddr,
  input wire logic [1:0]                   fixedAttrRaw,
  input wire logic                         defaultTypeEnable,
  input wire sysmt_pkg::sysmt_memtype_type defaultMemType,
  input wire logic                         rangeHit,
  input wire sysmt_pkg::sysmt_memtype_type rangeMemType,
  input wire logic [PA_W-1:0]              highMemoryCeiling,
  input wire sysmt_pkg::sysmt_cfg_type     cfgOut,
  input wire logic [1:0]                   fixedAttrEffective,
  input wire logic                         lowLimitActive,
  input wire logic                         ioRangeActive,
  input wire logic                         highLimitActive,
  input wire sysmt_pkg::sysmt_memtype_type memTypeOut
);
  import sysmt_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic [31:0] cfgWord;
  logic        inWin;
  assign cfgWord = {9'h0, cfgOut.forceWritebackHigh, cfgOut.highLimitEnable,
                    cfgOut.variableRangeEnable, cfgOut.fixedAttrModifyEnable,
                    cfgOut.fixedAttrEnable, 18'h0};
  // window only counts with the ceiling register enabled
  assign inWin = cfgOut.forceWritebackHigh && cfgOut.highLimitEnable &&
                 physAddr >= 40'h0100000000 && physAddr < highMemoryCeiling;
  sequence cfgDone;
    cfgRsp.valid && cfgRsp.hit;
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_CFG_LAT: assert property (cfgRsp.valid |-> $past(cfgReq.rdEn || cfgReq.wrEn, 2)
    ##1 !cfgRsp.valid) else $error("config answer timing wrong");
  AST_CFG_HIT: assert property (cfgRsp.valid |-> cfgRsp.hit == ($past(cfgReq.addr) ==
    32'hc0010010) && (cfgRsp.hit || cfgRsp.rdata == 32'h0)) else $error("bad hit");
  AST_CFG_WR: assert property (cfgDone and $past(cfgReq.wrEn) |-> cfgWord ==
    ($past(cfgReq.wdata) & 32'h007c0000)) else $error("config write wrong");
  AST_CFG_RD: assert property (cfgDone and $past(cfgReq.rdEn) |-> cfgRsp.rdata ==
    cfgWord) else $error("config read wrong");
  AST_ATTR_RD: assert property (attrRdValid |-> $past(attrRdEn, 2) && (attrRdData == 2'h0
    || $past(cfgOut.fixedAttrModifyEnable, 2))) else $error("attr read wrong");
  AST_FIX_EFF: assert property ($past(reset_n) |-> fixedAttrEffective == ($past(
    cfgOut.fixedAttrEnable) ? $past(fixedAttrRaw) : 2'h0)) else $error("fixed attr");
  AST_LIMITS: assert property ($past(reset_n) |-> {lowLimitActive, ioRangeActive,
    highLimitActive} == {{2{$past(cfgOut.variableRangeEnable)}},
    $past(cfgOut.highLimitEnable)}) else $error("limit enables wrong");
  AST_MT_UC: assert property ($past(reset_n) && !$past(defaultTypeEnable) |->
    memTypeOut == SYSMT_UC) else $error("type not uncached");
  AST_MT_RANGE: assert property ($past(reset_n) && $past(defaultTypeEnable && rangeHit)
    |-> memTypeOut == $past(rangeMemType)) else $error("range type lost");
  AST_MT_WIN: assert property ($past(reset_n) && $past(defaultTypeEnable && !rangeHit) |->
    memTypeOut == ($past(inWin) ? SYSMT_WB : $past(defaultMemType)))
    else $error("default type wrong");
endmodule : sysmt_ctrl_sva

/* File: sim/sysmt_ctrl_tb.sv */
// Purpose: self-checking bench for sysmt_ctrl
// Assumes: inputs change on falling mclk edges
// Notes:   checker bound here by port name
bind sysmt_ctrl sysmt_ctrl_sva #(.ATTR_AW(ATTR_AW), .PA_W(PA_W)) chk_u (.*);
module sysmt_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sysmt_pkg::*;
  logic mclk, reset_n, attrWrEn, attrRdEn, attrRdValid, defaultTypeEnable, rangeHit;
  logic lowLimitActive, ioRangeActive, highLimitActive;
  logic [6:0]  attrIdx;
  logic [1:0]  attrWrData, attrRdData, fixedAttrRaw, fixedAttrEffective;
  logic [39:0] physAddr, highMemoryCeiling;
  logic [31:0] rd;
  sysmt_req_type     cfgReq;
  sysmt_rsp_type     cfgRsp;
  sysmt_cfg_type     cfgOut;
  sysmt_memtype_type defaultMemType, rangeMemType, memTypeOut;
  int numErrors, samplesChecked;
  logic [31:0] vals [4] = '{32'hff83ffff, 32'h00140000, 32'h00280000, 32'h007c0000};

  sysmt_ctrl dut_u (.*);

  task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // answers are pulses, so look just after each rising edge
  task automatic waitRsp(input bit attr);
    repeat (8) begin
      @(posedge mclk);
      #1;
      if ((attr ? attrRdValid : cfgRsp.valid) === 1'b1) return;
    end
    numErrors++;
    summarize();
  endtask : waitRsp

  // released before the next edge, else an idle block takes it again
  task automatic cfgAcc(input logic wr, input logic [31:0] a, d, input logic hit);
    @(negedge mclk);
    cfgReq = '{rdEn: !wr, wrEn: wr, addr: a, wdata: d};
    waitRsp(1'b0);
    rd = cfgRsp.rdata;
    chk("hit", cfgRsp.hit, hit);
    @(negedge mclk);
    cfgReq = '0;
  endtask : cfgAcc

  task automatic attrAcc(input logic wr, input logic [6:0] idx, input logic [1:0] d);
    @(negedge mclk);
    attrWrEn = wr;
    attrRdEn = !wr;
    attrIdx = idx;
    attrWrData = d;
    @(negedge mclk);
    attrWrEn = 1'b0;
    attrRdEn = 1'b0;
    if (!wr) waitRsp(1'b1);
  endtask : attrAcc

  task automatic look(input logic dte, hit, input logic [39:0] pa, input logic [2:0] exp);
    @(negedge mclk);
    defaultTypeEnable = dte;
    rangeHit = hit;
    physAddr = pa;
    @(negedge mclk);
    chk("memType", memTypeOut, exp);
  endtask : look

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    {reset_n, attrWrEn, attrRdEn, defaultTypeEnable, rangeHit} = '0;
    {cfgReq, attrIdx, attrWrData, physAddr, numErrors, samplesChecked} = '0;
    fixedAttrRaw = 2'h2;
    defaultMemType = SYSMT_WP;
    rangeMemType = SYSMT_WT;
    highMemoryCeiling = 40'h0200000000;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    cfgAcc(1'b1, 32'hc0010014, 32'hffffffff, 1'b0);
    chk("unmapped", rd, 32'h0);
    cfgAcc(1'b0, 32'hc0010010, 32'h0, 1'b1);
    chk("cfgReset", rd, 32'h0);
    foreach (vals[i]) begin
      cfgAcc(1'b1, 32'hc0010010, vals[i], 1'b1);
      cfgAcc(1'b0, 32'hc0010010, 32'h0, 1'b1);
      chk("cfgWord", rd, vals[i] & 32'h007c0000);
      chk("fixedEff", fixedAttrEffective, vals[i][18] ? 2'h2 : 2'h0);
      chk("limits", {ioRangeActive, lowLimitActive}, {2{vals[i][20]}});
      chk("high", highLimitActive, vals[i][21]);
    end
    attrAcc(1'b1, 7'h57, 2'h3);
    attrAcc(1'b0, 7'h57, 2'h0);
    chk("attrRd", attrRdData, 2'h3);
    cfgAcc(1'b1, 32'hc0010010, 32'h00740000, 1'b1);
    attrAcc(1'b1, 7'h57, 2'h1);
    attrAcc(1'b0, 7'h57, 2'h0);
    chk("attrMasked", attrRdData, 2'h0);
    cfgAcc(1'b1, 32'hc0010010, 32'h00680000, 1'b1);
    attrAcc(1'b0, 7'h57, 2'h0);
    chk("attrKept", attrRdData, 2'h3);
    look(1'b0, 1'b1, 40'h0100000000, SYSMT_UC);
    look(1'b1, 1'b1, 40'h0100000000, SYSMT_WT);
    look(1'b1, 1'b0, 40'h0100000000, SYSMT_WB);
    look(1'b1, 1'b0, 40'h00ffffffff, SYSMT_WP);
    look(1'b1, 1'b0, 40'h0200000000, SYSMT_WP);
    cfgAcc(1'b1, 32'hc0010010, 32'h00200000, 1'b1);
    look(1'b1, 1'b0, 40'h0100000000, SYSMT_WP);
    // force bit plus fixed enable: no window without the ceiling enabled
    cfgAcc(1'b1, 32'hc0010010, 32'h00440000, 1'b1);
    fixedAttrRaw = 2'h1;
    look(1'b1, 1'b0, 40'h0100000000, SYSMT_WP);
    chk("fixedEff1", fixedAttrEffective, 2'h1);
    summarize();
  end
endmodule : sysmt_ctrl_tb
